// [can_lin_rate_defs.vh]
// constants for the can/lin bit-rate configuration block
`ifndef CAN_LIN_RATE_DEFS_VH
`define CAN_LIN_RATE_DEFS_VH
// bit-rate word mode nibbles
`define MODE_PLAIN        4'h0
`define MODE_CUSTOM       4'h8
`define MODE_PRECISE      4'hC
// normal custom field positions
`define NC_JUMP_HI        25
`define NC_JUMP_LO        24
`define NC_POST_HI        22
`define NC_POST_LO        20
`define NC_PRE_HI         19
`define NC_PRE_LO         16
// high-precision field positions
`define HP_JUMP_HI        27
`define HP_JUMP_LO        24
`define HP_POST_HI        23
`define HP_POST_LO        20
`define HP_PRE_HI         19
`define HP_PRE_LO         14
`define TQ_HI             13
`define TQ_LO             0
// quantum limits in ns
`define TQ_MAX            14'h3200
`define NC_TQ_STEP        14'h007D
`define HP_TQ_STEP        14'h0019
// lin range
`define LIN_MIN_RATE      32'h0000_0960
`define LIN_MAX_RATE      32'h0000_4E20
// clock rate for divisor math, hz
`define REF_CLK_HZ        32'h0EE6_B280
// uart oversampling
`define UART_OVERSAMPLE   32'h0000_0010
// transceiver dominant timeout in us
`define DOM_TIMEOUT_US    32'h0000_1770
// reset values
`define RST_CAN_RATE      32'h0007_A120
`define RST_LIN_RATE      32'h0000_4B00
`define RST_BREAK_BITS    8'h0D
`endif

// [sync2.v]
// two-flop synchroniser for a pin-level input
`default_nettype none
module sync2 (
  // clock and reset
  input  wire i_ref_clk,
  input  wire i_reset,
  input  wire i_ce,
  // level in and out
  input  wire i_async,
  output wire o_sync
);
  reg meta_q;
  reg sync_q;
  // first flop feeds only the second
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (i_ce) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule // sync2
`default_nettype wire

// [can_word_check.v]
// decoder and range check for a can bit-rate word
`include "can_lin_rate_defs.vh"
`default_nettype none
module can_word_check (
  // word in
  input  wire [31:0] i_word,
  // decoded timing
  output reg         o_ok,
  output reg  [1:0]  o_mode,
  output reg  [3:0]  o_jump,
  output reg  [3:0]  o_post,
  output reg  [5:0]  o_pre,
  output reg  [13:0] o_tq
);
  // plain rate table membership
  function plain_ok;
    input [31:0] r;
    begin
      case (r)
        32'd33333, 32'd40000, 32'd50000, 32'd62500, 32'd80000, 32'd83333,
        32'd100000, 32'd125000, 32'd160000, 32'd200000, 32'd250000,
        32'd400000, 32'd500000, 32'd800000, 32'd1000000: plain_ok = 1'b1;
        default: plain_ok = 1'b0;
      endcase
    end
  endfunction
  // quantum range and step check
  function tq_ok;
    input [13:0] q;
    input [13:0] step;
    begin
      tq_ok = (q >= step) && (q <= `TQ_MAX) && ((q % step) == 14'h0000);
    end
  endfunction
  // decode by top nibble
  always @* begin
    o_ok   = 1'b0;
    o_mode = 2'd0;
    o_jump = 4'h0;
    o_post = 4'h0;
    o_pre  = 6'h00;
    o_tq   = i_word[`TQ_HI:`TQ_LO];
    case (i_word[31:28])
      `MODE_PLAIN: begin
        o_ok   = plain_ok(i_word);
        o_mode = 2'd0;
      end
      `MODE_CUSTOM: begin
        o_jump = {2'b00, i_word[`NC_JUMP_HI:`NC_JUMP_LO]};
        o_post = {1'b0, i_word[`NC_POST_HI:`NC_POST_LO]};
        o_pre  = {2'b00, i_word[`NC_PRE_HI:`NC_PRE_LO]};
        o_mode = 2'd1;
        o_ok   = (o_pre != 6'h00) && tq_ok(o_tq, `NC_TQ_STEP);
      end
      `MODE_PRECISE: begin
        o_jump = i_word[`HP_JUMP_HI:`HP_JUMP_LO];
        o_post = i_word[`HP_POST_HI:`HP_POST_LO];
        o_pre  = i_word[`HP_PRE_HI:`HP_PRE_LO];
        o_mode = 2'd2;
        o_ok   = (o_pre != 6'h00) && tq_ok(o_tq, `HP_TQ_STEP);
      end
      default: o_ok = 1'b0;
    endcase
  end
endmodule // can_word_check
`default_nettype wire

// [can_lin_bit_rate_config.v]
// configuration and start-up logic for a can port and a lin port
`include "can_lin_rate_defs.vh"
`default_nettype none
// Functional notes
// - allow-without-power skips power check
// - otherwise missing power raises error
// - termination 0 off, applied at start
// - routed trigger starts the interface
// - zero top nibble: plain can rate
// - only fifteen listed can rates
// - nibble 8: normal custom can timing
// - nibble c: high-precision can timing
// - jump width used plus one
// - post segment used plus one
// - pre segment 1 up, plus one
// - quantum range and step checked
// - bit is one plus both segments
// - lin plain rate 2400 to 20000
// - lin nibble 8: low 16 bits
// - uart divisor from lin rate
// - break length checked against timeout
module can_lin_bit_rate_config #(
  parameter DIV_W = 16
) (
  // clock, reset, enable
  input  wire             i_ref_clk,
  input  wire             i_reset,
  input  wire             i_ce,
  // software configuration
  input  wire             i_can_rate_wr,
  input  wire [31:0]      i_can_bit_rate_word,
  input  wire             i_lin_rate_wr,
  input  wire [31:0]      i_lin_bit_rate_word,
  input  wire             i_break_wr,
  input  wire [7:0]       i_break_bits,
  input  wire             i_opt_wr,
  input  wire             i_allow_start_without_power,
  input  wire             i_termination,
  input  wire             i_trig_route_en,
  // start and stop
  input  wire             i_start_req,
  input  wire             i_stop_req,
  input  wire             i_start_trigger_source,
  input  wire             i_lin_bus_power,
  // status
  output reg              o_running,
  output reg              o_missing_bus_power_error,
  output reg              o_config_error,
  output reg              o_write_refused,
  output reg              o_break_timeout_error,
  output reg              o_lin_termination_en,
  // can timing
  output reg  [1:0]       o_can_mode,
  output reg  [31:0]      o_can_plain_rate,
  output reg  [4:0]       o_resync_jump_width,
  output reg  [6:0]       o_pre_sample_segment,
  output reg  [4:0]       o_post_sample_segment,
  output reg  [13:0]      o_time_quantum_ns,
  output reg  [7:0]       o_can_bit_quanta,
  // lin timing
  output reg  [15:0]      o_lin_rate,
  output reg  [DIV_W-1:0] o_uart_divisor
);

  //////////////////////////////////////////////////////////////////////////////
  // state and helpers
  localparam ST_STOPPED = 2'd0;
  localparam ST_CHECK   = 2'd1;
  localparam ST_RUN     = 2'd2;

  // sequencer state
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;

  // stored settings, loaded only while stopped
  reg  [7:0]  break_bits_q;
  reg         allow_q;
  reg         term_q;
  reg         route_q;

  // trigger edge memory and synchronised pin levels
  reg         trig_prev_q;
  wire        trig_s;
  wire        power_s;

  // can word decoder outputs, valid in the cycle of the word
  wire        cw_ok;
  wire [1:0]  cw_mode;
  wire [3:0]  cw_jump;
  wire [3:0]  cw_post;
  wire [5:0]  cw_pre;
  wire [13:0] cw_tq;

  // divisor: clock over oversampled rate, zero rate guarded
  // truncating division; the error stays below one clock per sample
  function [31:0] uart_div;
    input [15:0] rate;
    begin
      if (rate == 16'h0000) uart_div = 32'h0000_0000;
      else uart_div = `REF_CLK_HZ / ({16'h0000, rate} * `UART_OVERSAMPLE);
    end
  endfunction

  // break duration in us reaches or exceeds transceiver timeout
  // a zero rate means an endless break, so it is always flagged
  function break_too_long;
    input [15:0] rate;
    input [7:0]  bits;
    reg   [31:0] dur_us;
    begin
      dur_us = 32'h0000_0000;
      if (rate == 16'h0000) begin
        break_too_long = 1'b1;
      end else begin
        dur_us = ({24'h00_0000, bits} * 32'd1000000) / {16'h0000, rate};
        break_too_long = dur_us >= `DOM_TIMEOUT_US;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // start trigger pin
  sync2 u_sync_trig (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_async   (i_start_trigger_source),
    .o_sync    (trig_s)
  );

  // lin bus supply sense pin
  sync2 u_sync_pwr (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_async   (i_lin_bus_power),
    .o_sync    (power_s)
  );

  // can word decoder
  // purely combinational, so a write is judged in the cycle it lands
  can_word_check u_can_chk (
    .i_word (i_can_bit_rate_word),
    .o_ok   (cw_ok),
    .o_mode (cw_mode),
    .o_jump (cw_jump),
    .o_post (cw_post),
    .o_pre  (cw_pre),
    .o_tq   (cw_tq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // start sequencing
  // stopped -> check on a start event; check -> run when power is present or
  // the check is waived, else back to stopped with the error raised; run ->
  // stopped on a stop request. a start request while running is ignored.
  wire trig_rise = trig_s & ~trig_prev_q;
  wire start_ev  = route_q ? trig_rise : i_start_req;
  wire stopped   = (state_q == ST_STOPPED);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STOPPED: begin
        if (start_ev) state_d = ST_CHECK;
      end
      ST_CHECK: begin
        if (!allow_q && !power_s) state_d = ST_STOPPED;
        else state_d = ST_RUN;
      end
      ST_RUN: begin
        if (i_stop_req) state_d = ST_STOPPED;
      end
      default: state_d = ST_STOPPED;
    endcase
  end

  // state register and trigger edge memory; the history runs in every state,
  // so a pin already high when routing is enabled gives no edge
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q     <= ST_STOPPED;
      trig_prev_q <= 1'b0;
    end else if (i_ce) begin
      state_q     <= state_d;
      trig_prev_q <= trig_s;
    end
  end

  // status flags; the power error is sticky until the next start attempt
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_running                 <= 1'b0;
      o_missing_bus_power_error <= 1'b0;
      o_lin_termination_en      <= 1'b0;
    end else if (i_ce) begin
      // taken from the next state so it lines up with state_q
      o_running <= (state_d == ST_RUN);
      if (stopped && start_ev) begin
        o_missing_bus_power_error <= 1'b0;
        o_lin_termination_en      <= term_q;
      end
      if (state_q == ST_CHECK) begin
        o_missing_bus_power_error <= !allow_q && !power_s;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration writes
  // every write is taken only while stopped; one landing in the check or
  // run state is dropped and answered by the refusal pulse alone
  localparam [31:0] LIN_RST_WORD = `RST_LIN_RATE;

  wire [15:0] lin_new    = i_lin_bit_rate_word[15:0];
  wire        lin_plain  = (i_lin_bit_rate_word[31:28] == `MODE_PLAIN) &&
                           (i_lin_bit_rate_word >= `LIN_MIN_RATE) &&
                           (i_lin_bit_rate_word <= `LIN_MAX_RATE);
  // custom lin takes low 16 bits
  wire        lin_custom = (i_lin_bit_rate_word[31:28] == `MODE_CUSTOM);
  // any other top nibble is a configuration error
  wire        lin_ok     = lin_plain || lin_custom;
  wire        any_wr     = i_can_rate_wr | i_lin_rate_wr | i_break_wr | i_opt_wr;
  // write strobes qualified by the stopped state
  wire        can_take   = stopped && i_can_rate_wr;
  wire        lin_take   = stopped && i_lin_rate_wr;
  wire        brk_take   = stopped && i_break_wr && !i_lin_rate_wr;
  wire        opt_take   = stopped && i_opt_wr;
  wire [31:0] div_new    = uart_div(lin_new);
  wire [31:0] div_cur    = uart_div(o_lin_rate);

  //////////////////////////////////////////////////////////////////////////////
  // refusal pulse: one cycle for each write attempt outside the stopped state
  // the write itself is dropped; settings and flags stay as they were
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_write_refused <= 1'b0;
    end else if (i_ce) begin
      o_write_refused <= any_wr && !stopped;
    end
  end

  // start options; they reach the port only through the start sequence
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      allow_q <= 1'b0;
      term_q  <= 1'b0;
      route_q <= 1'b0;
    end else if (i_ce) begin
      if (opt_take) begin
        allow_q <= i_allow_start_without_power;
        term_q  <= i_termination;
        route_q <= i_trig_route_en;
      end
    end
  end

  // error flag follows the latest rate write; when a can and a lin write
  // land together, a bad word on either side wins over a good one
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_config_error <= 1'b0;
    end else if (i_ce) begin
      if (can_take || lin_take) begin
        o_config_error <= (can_take && !cw_ok) || (lin_take && !lin_ok);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // can timing; a rejected word leaves every timing output as it was
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_can_mode            <= 2'd0;
      o_can_plain_rate      <= `RST_CAN_RATE;
      o_resync_jump_width   <= 5'd1;
      o_pre_sample_segment  <= 7'd1;
      o_post_sample_segment <= 5'd1;
      o_time_quantum_ns     <= 14'h0000;
      o_can_bit_quanta      <= 8'd3;
    end else if (i_ce) begin
      if (can_take && cw_ok) begin
        o_can_mode            <= cw_mode;
        // plain rate kept only in plain mode
        o_can_plain_rate      <= (cw_mode == 2'd0) ? i_can_bit_rate_word : 32'h0000_0000;
        o_resync_jump_width   <= {1'b0, cw_jump} + 5'd1;
        o_pre_sample_segment  <= {1'b0, cw_pre} + 7'd1;
        o_post_sample_segment <= {1'b0, cw_post} + 5'd1;
        o_time_quantum_ns     <= cw_tq;
        o_can_bit_quanta      <= 8'd1 + {2'b00, cw_pre} + 8'd1 + {4'h0, cw_post} + 8'd1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lin timing and break check; a lin rate write beats a break write in the
  // same cycle, so a break length is only taken with no rate write pending
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      break_bits_q          <= `RST_BREAK_BITS;
      o_break_timeout_error <= 1'b0;
      o_lin_rate            <= LIN_RST_WORD[15:0];
      o_uart_divisor        <= {DIV_W{1'b0}};
    end else if (i_ce) begin
      if (lin_take && lin_ok) begin
        // custom rates use the low half only
        o_lin_rate            <= lin_new;
        o_uart_divisor        <= div_new[DIV_W-1:0];
        o_break_timeout_error <= break_too_long(lin_new, break_bits_q);
      end else if (brk_take) begin
        // divisor refreshed too, so it is valid before any rate write
        break_bits_q          <= i_break_bits;
        o_break_timeout_error <= break_too_long(o_lin_rate, i_break_bits);
        o_uart_divisor        <= div_cur[DIV_W-1:0];
      end
    end
  end

endmodule // can_lin_bit_rate_config
`default_nettype wire

// [can_lin_bit_rate_config_props.sv]
// assertion checker for the can/lin bit-rate configuration block
`default_nettype none
module can_lin_bit_rate_config_chk #(parameter DIV_W = 16) (
  // clock and reset
  input wire logic             i_ref_clk,
  input wire logic             i_reset,
  // configuration requests
  input wire logic             i_ce,
  input wire logic             i_can_rate_wr,
  input wire logic [31:0]      i_can_bit_rate_word,
  input wire logic             i_lin_rate_wr,
  input wire logic [31:0]      i_lin_bit_rate_word,
  // status and timing
  input wire logic             o_running,
  input wire logic             o_missing_bus_power_error,
  input wire logic             o_config_error,
  input wire logic             o_write_refused,
  input wire logic             o_lin_termination_en,
  input wire logic [1:0]       o_can_mode,
  input wire logic [4:0]       o_resync_jump_width,
  input wire logic [6:0]       o_pre_sample_segment,
  input wire logic [4:0]       o_post_sample_segment,
  input wire logic [13:0]      o_time_quantum_ns,
  input wire logic [7:0]       o_can_bit_quanta,
  input wire logic [DIV_W-1:0] o_uart_divisor
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////
  // single writes while stopped; a write in the check state still pulses refused
  wire logic [31:0] w   = i_can_bit_rate_word;
  wire logic [31:0] l   = i_lin_bit_rate_word;
  wire logic        cwr = i_ce && i_can_rate_wr && !i_lin_rate_wr && !o_running;
  wire logic        lwr = i_ce && i_lin_rate_wr && !i_can_rate_wr && !o_running;
  // field legality; a zero quantum fails the range test
  wire logic        tq_in = w[13:0] != 0 && w[13:0] <= 14'h3200;
  wire logic        nc_ok = w[31:28] == 4'h8 && w[19:16] != 0 && w[13:0] % 125 == 0 && tq_in;
  wire logic        hp_ok = w[31:28] == 4'hC && w[19:14] != 0 && w[13:0] % 25 == 0 && tq_in;
  wire logic        l_in  = l >= 2400 && l <= 20000;
  wire logic        p_ok  = w inside {33333, 40000, 50000, 62500, 80000, 83333, 100000, 125000,
                                      160000, 200000, 250000, 400000, 500000, 800000, 1000000};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  // refuse while running
  a_refused_while_run: assert property (o_running && i_ce && (i_can_rate_wr || i_lin_rate_wr)
    |=> o_write_refused) else $error("write while running was taken");
  a_bit_quanta_sum: assert property (o_can_mode != 2'd0
    |-> o_can_bit_quanta == 8'd1 + o_pre_sample_segment + o_post_sample_segment) else $error("bit quanta wrong");
  a_normal_decode: assert property (cwr && nc_ok |=> o_write_refused || (o_can_mode == 2'd1
    && o_resync_jump_width == $past(w[25:24]) + 5'd1 && o_post_sample_segment == $past(w[22:20]) + 5'd1
    && o_pre_sample_segment == $past(w[19:16]) + 7'd1 && o_time_quantum_ns == $past(w[13:0])))
    else $error("normal custom word decoded wrong");
  a_precise_decode: assert property (cwr && hp_ok |=> o_write_refused || (o_can_mode == 2'd2
    && o_resync_jump_width == $past(w[27:24]) + 5'd1 && o_post_sample_segment == $past(w[23:20]) + 5'd1
    && o_pre_sample_segment == $past(w[19:14]) + 7'd1 && o_time_quantum_ns == $past(w[13:0])))
    else $error("precise custom word decoded wrong");
  a_bad_custom_kept: assert property (cwr && (w[31:28] == 4'h8 || w[31:28] == 4'hC) && !nc_ok && !hp_ok
    |=> o_write_refused || (o_config_error && $stable(o_time_quantum_ns) && $stable(o_pre_sample_segment)))
    else $error("bad custom word not rejected");
  a_plain_rate_list: assert property (cwr && w[31:28] == 4'h0
    |=> o_write_refused || o_config_error == !$past(p_ok)) else $error("plain rate check wrong");
  a_lin_plain_range: assert property (lwr && l[31:28] == 4'h0 |=> o_write_refused
    || (o_config_error == !$past(l_in) && (!$past(l_in)
    || o_uart_divisor == DIV_W'(32'd250000000 / (32'd16 * $past(l)))))) else $error("lin rate check wrong");
  a_power_error_stops: assert property (o_missing_bus_power_error |-> !o_running)
    else $error("running with missing bus power");
  a_term_at_start: assert property ($changed(o_lin_termination_en)
    |-> !o_running ##1 (o_running || o_missing_bus_power_error)) else $error("termination changed outside start");
endmodule // can_lin_bit_rate_config_chk
bind can_lin_bit_rate_config can_lin_bit_rate_config_chk #(.DIV_W(DIV_W)) u_chk (.*);
`default_nettype wire

// [lin_bus_node.sv]
// far-side model: lin bus supply and routed start trigger pin
`default_nettype none
module lin_bus_node (
  // bench controls
  input  wire logic i_pwr_en,
  input  wire logic i_fire,
  // pins towards the block
  output var  logic o_lin_bus_power,
  output var  logic o_start_trigger
);
  timeunit 1ns;
  timeprecision 100ps;
  // both pins start low: no supply, no trigger
  initial begin
    o_lin_bus_power = 1'b0;
    o_start_trigger = 1'b0;
  end
  // supply moves off the clock grid, so the synchroniser is really exercised
  always @(i_pwr_en) o_lin_bus_power <= #3.7 i_pwr_en;
  // trigger held ten cycles so a two-flop synchroniser cannot miss it
  always @(posedge i_fire) begin
    #2.3 o_start_trigger = 1'b1;
    #40 o_start_trigger = 1'b0;
  end
endmodule // lin_bus_node
`default_nettype wire

// [test_can_lin_bit_rate_config.sv]
// self-checking bench for the can/lin bit-rate configuration block
`default_nettype none
module test_can_lin_bit_rate_config;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_ref_clk, i_reset, i_ce, i_can_rate_wr, i_lin_rate_wr, i_break_wr, i_opt_wr, i_stop_req;
  logic        i_allow_start_without_power, i_termination, i_trig_route_en, i_start_req, pwr_en, fire;
  logic        i_start_trigger_source, i_lin_bus_power, o_running, o_missing_bus_power_error;
  logic        o_config_error, o_write_refused, o_break_timeout_error, o_lin_termination_en;
  logic [31:0] i_can_bit_rate_word, i_lin_bit_rate_word, o_can_plain_rate, r;
  logic [7:0]  i_break_bits, o_can_bit_quanta;
  logic [1:0]  o_can_mode;
  logic [4:0]  o_resync_jump_width, o_post_sample_segment;
  logic [6:0]  o_pre_sample_segment;
  logic [13:0] o_time_quantum_ns, last_tq;
  logic [15:0] o_lin_rate, o_uart_divisor;
  logic [31:0] seed = 32'h0000_b5e2;
  logic [31:0] bad[5] = '{32'h8010_007E, 32'h8000_007D, 32'hC010_0000, 32'h8010_32C8, 32'hC000_0019};
  int unsigned rates[15] = '{33333, 40000, 50000, 62500, 80000, 83333, 100000, 125000, 160000, 200000,
                             250000, 400000, 500000, 800000, 1000000};
  int          error_cnt, checks_done, k;
  ////////////////////////////////////////
  can_lin_bit_rate_config #(.DIV_W(16)) u_dut (.*);
  lin_bus_node u_node (.i_pwr_en(pwr_en), .i_fire(fire), .o_lin_bus_power(i_lin_bus_power),
                       .o_start_trigger(i_start_trigger_source));
  // 250 mhz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // case equality, so an unknown never matches
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one-cycle request; the outputs of its edge are settled on return
  task automatic pulse(ref logic s);
    @(negedge i_ref_clk) s = 1'b1;
    @(negedge i_ref_clk) s = 1'b0;
  endtask
  task automatic can_wr(logic [31:0] w);
    i_can_bit_rate_word = w;
    pulse(i_can_rate_wr);
  endtask
  task automatic can_cust(logic hp, logic [3:0] j, logic [3:0] p2, logic [5:0] p1, logic [13:0] tq);
    can_wr(hp ? {4'hC, j, p2, p1, tq} : {6'h20, j[1:0], 1'b0, p2[2:0], p1[3:0], 2'b00, tq});
    last_tq = tq;
    chk("mode", o_can_mode, hp ? 2 : 1);
    chk("jump", o_resync_jump_width, j + 1);
    chk("post", o_post_sample_segment, p2 + 1);
    chk("pre", o_pre_sample_segment, p1 + 1);
    chk("tq", o_time_quantum_ns, tq);
    chk("quanta", o_can_bit_quanta, 3 + p1 + p2);
  endtask
  task automatic lin_wr(logic [31:0] w, logic ok);
    i_lin_bit_rate_word = w;
    pulse(i_lin_rate_wr);
    chk("lin_err", o_config_error, !ok);
    if (ok) begin
      chk("lin_rate", o_lin_rate, w[15:0]);
      chk("divisor", o_uart_divisor, 250000000 / (16 * w[15:0]));
    end
  endtask
  task automatic brk(logic [7:0] b, logic err);
    i_break_bits = b;
    pulse(i_break_wr);
    chk("break_err", o_break_timeout_error, err);
  endtask
  task automatic opts(logic a, logic t, logic rt);
    {i_allow_start_without_power, i_termination, i_trig_route_en} = {a, t, rt};
    pulse(i_opt_wr);
  endtask
  task automatic start(logic run, logic term);
    pulse(i_start_req);
    chk("term", o_lin_termination_en, term);
    @(negedge i_ref_clk);
    chk("running", o_running, run);
    chk("no_power", o_missing_bus_power_error, !run);
  endtask
  ////////////////////////////////////////
  // main sequence; every write is made while stopped unless refusal is the point
  initial begin
    {i_reset, i_ce, i_can_rate_wr, i_lin_rate_wr, i_break_wr, i_opt_wr, i_start_req, i_stop_req} = 8'hC0;
    {i_allow_start_without_power, i_termination, i_trig_route_en, pwr_en, fire} = '0;
    {i_can_bit_rate_word, i_lin_bit_rate_word, i_break_bits} = '0;
    repeat (6) @(negedge i_ref_clk);
    i_reset = 1'b0;
    chk("rate", o_can_plain_rate, 500000);
    chk("lin", o_lin_rate, 19200);
    chk("term", o_lin_termination_en, 0);
    $display("test reset over");
    foreach (rates[i]) begin
      can_wr(rates[i]);
      chk("can_rate", o_can_plain_rate, rates[i]);
      chk("can_err", o_config_error, 0);
    end
    can_wr(33334);
    chk("can_err", o_config_error, 1);
    chk("can_kept", o_can_plain_rate, 1000000);
    $display("test plain over");
    can_cust(0, 0, 1, 4, 125);
    can_cust(1, 15, 15, 63, 12800);
    for (k = 0; k < 16; k++) begin
      r = rnd();
      if (r[31]) can_cust(1, r[3:0], r[7:4], 1 + r[13:8] % 63, 25 * (1 + r[24:16] % 512));
      else can_cust(0, r[1:0], r[6:4], 1 + r[11:8] % 15, 125 * (1 + r[22:16] % 102));
    end
    foreach (bad[i]) begin
      can_wr(bad[i]);
      chk("bad_err", o_config_error, 1);
      chk("bad_tq", o_time_quantum_ns, last_tq);
    end
    $display("test custom over");
    lin_wr(2400, 1);
    lin_wr(20000, 1);
    lin_wr(2399, 0);
    lin_wr(20001, 0);
    lin_wr(32'h4000_0960, 0);
    lin_wr(32'h8001_2345, 1);
    for (k = 0; k < 8; k++) begin
      r = rnd();
      lin_wr({4'h8, r[27:16], 16'd1000 + r[15:0] % 16'd64000}, 1);
    end
    lin_wr(2500, 1);
    brk(15, 1);
    brk(14, 0);
    $display("test lin over");
    opts(0, 1, 0);
    start(0, 1);
    pwr_en = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    start(1, 1);
    can_wr(32'h8014_007D);
    chk("refused", o_write_refused, 1);
    chk("kept", o_time_quantum_ns, last_tq);
    pulse(i_stop_req);
    chk("stopped", o_running, 0);
    opts(1, 0, 0);
    chk("term_held", o_lin_termination_en, 1);
    pwr_en = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    start(1, 0);
    pulse(i_stop_req);
    opts(1, 0, 1);
    pulse(i_start_req);
    repeat (2) @(negedge i_ref_clk);
    chk("soft_ignored", o_running, 0);
    fire = 1'b1;
    // bounded wait; a trigger that never starts the port counts as a mismatch
    for (k = 0; k < 20 && o_running !== 1'b1; k++) @(negedge i_ref_clk);
    chk("trig_run", o_running, 1);
    $display("test start over");
    summarize();
  end
endmodule // test_can_lin_bit_rate_config
`default_nettype wire
